// file: uart_lfs_pkg.sv
package uart_lfs_pkg;

  // ----------------------------------------------------------------
  // register offsets on the host port
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;  // receive buffer / transmit holder / divisor low
  localparam logic [2:0] ADDR_IER  = 3'h1;  // interrupt enable / divisor high
  localparam logic [2:0] ADDR_IIR  = 3'h2;  // identification on read, fifo control on write
  localparam logic [2:0] ADDR_LCR  = 3'h3;
  localparam logic [2:0] ADDR_LSR  = 3'h5;
  localparam logic [2:0] ADDR_MSR  = 3'h6;

  // ----------------------------------------------------------------
  // line_control field positions
  // ----------------------------------------------------------------
  localparam int LC_STB   = 2;
  localparam int LC_PEN   = 3;
  localparam int LC_EPS   = 4;
  localparam int LC_STICK = 5;
  localparam int LC_BRK   = 6;
  localparam int LC_DIVISOR_ACCESS_FIELD  = 7;

  // fifo control bits
  localparam int FC_EN    = 0;
  localparam int FC_RXCLR = 1;
  localparam int FC_TXCLR = 2;

  // ----------------------------------------------------------------
  // identification codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_RLS  = 4'h6;
  localparam logic [3:0] IID_RDA  = 4'h4;
  localparam logic [3:0] IID_HOLDER_EMPTY_FLAG = 4'h2;
  localparam logic [3:0] IID_MS   = 4'h0;
  localparam logic [1:0] IIR_FIFO = 2'h3;

  localparam logic [7:0]  LCR_RST = 8'h00;
  localparam logic [3:0]  IER_RST = 4'h0;
  localparam logic [7:0]  DIV_RST = 8'h00;

  // ----------------------------------------------------------------
  // sixteen-times sample counts
  // ----------------------------------------------------------------
  localparam logic [3:0] SMP_MID  = 4'h7;   // mid-bit sample of the start bit
  localparam logic [4:0] BIT_LAST = 5'h0F;  // last tick of a whole bit
  localparam logic [4:0] STOP_15  = 5'h17;  // last tick of one and a half stop bits
  localparam logic [4:0] STOP_2   = 5'h1F;  // last tick of two stop bits
  localparam logic [1:0] BRK_HIGH = 2'h2;   // high samples needed after a break

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;

endpackage

// file: uart_line_format_status.sv
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
module uart_line_format_status
  import uart_lfs_pkg::*;
#(
  parameter int RX_DEPTH = 16,
  parameter int TX_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        tick16,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  input  wire logic [3:0]  modem_n,
  output logic             irq,
  output logic      [15:0] divisor,
  output logic             fifo_mode
);

  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam logic [RAW:0] RX_FULL = (RAW+1)'(RX_DEPTH);
  localparam logic [TAW:0] TX_FULL = (TAW+1)'(TX_DEPTH);

  // ----------------------------------------------------------------
  // format helpers shared by both directions
  // ----------------------------------------------------------------
  // index of the last data bit: 4, 5, 6 or 7
  function automatic logic [2:0] last_bit(input logic [7:0] lc);
    last_bit = {1'b1, lc[1:0]};
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lc);
    logic [7:0] m;
    m = d & (8'hFF >> (2'h3 - lc[1:0]));
    if (lc[LC_STICK]) par_bit = ~lc[LC_EPS];
    else par_bit = lc[LC_EPS] ? ^m : ~^m;
  endfunction

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  logic [7:0] lcr_r, dll_r, dlm_r, rdata_r;
  logic [3:0] ier_r;
  logic       fen_r;
  logic       oe_r, pe_r, fe_r, bi_r, holder_empty_flag_int_r, holder_empty_flag_d_r;
  logic [3:0] dlt_r, m1_r, m2_r, mprev_r;
  logic       rxs1_r, rxs2_r;

  wire divisor_access_field   = lcr_r[LC_DIVISOR_ACCESS_FIELD];
  wire wr_thr = wr && addr == ADDR_DATA && !divisor_access_field;
  wire wr_dll = wr && addr == ADDR_DATA && divisor_access_field;
  wire wr_ier = wr && addr == ADDR_IER && !divisor_access_field;
  wire wr_dlm = wr && addr == ADDR_IER && divisor_access_field;
  wire wr_fcr = wr && addr == ADDR_IIR;
  wire wr_lcr = wr && addr == ADDR_LCR;
  wire rd_rbr = rd && addr == ADDR_DATA && !divisor_access_field;
  wire rd_iir = rd && addr == ADDR_IIR;
  wire rd_lsr = rd && addr == ADDR_LSR;
  wire rd_msr = rd && addr == ADDR_MSR;
  // a fifo enable change flushes both queues; an explicit clear bit flushes only its own queue
  wire fen_chg = wr_fcr && (wdata[FC_EN] != fen_r);
  wire rx_clr  = wr_fcr && (wdata[FC_RXCLR] || fen_chg);
  wire tx_clr  = wr_fcr && (wdata[FC_TXCLR] || fen_chg);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lcr_r <= LCR_RST;
      ier_r <= IER_RST;
      dll_r <= DIV_RST;
      dlm_r <= DIV_RST;
      fen_r <= 1'b0;
    end else if (ce) begin
      if (wr_lcr) lcr_r <= wdata;
      if (wr_ier) ier_r <= wdata[3:0];
      if (wr_dll) dll_r <= wdata;
      if (wr_dlm) dlm_r <= wdata;
      if (wr_fcr) fen_r <= wdata[FC_EN];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {rxs1_r, rxs2_r} <= 2'h3;
      m1_r <= 4'hF;
      m2_r <= 4'hF;
      mprev_r <= 4'hF;
    end else if (ce) begin
      rxs1_r <= rx_pin;
      rxs2_r <= rxs1_r;
      m1_r <= modem_n;
      m2_r <= m1_r;
      mprev_r <= m2_r;
    end
  end
  wire rxd = rxs2_r;

  // ----------------------------------------------------------------
  // receive queue; depth one outside fifo mode
  // ----------------------------------------------------------------
  logic [10:0]  rxq [RX_DEPTH];  // {break, framing, parity, data}
  logic [RAW-1:0] rx_wp, rx_rp;
  logic [RAW:0] rx_cnt, rx_errs;
  logic         rx_done_r, head_new_d_r;
  logic [10:0]  rx_word_r;

  wire [RAW:0] rx_cap  = fen_r ? RX_FULL : (RAW+1)'(1);
  wire rx_pop   = rd_rbr && rx_cnt != '0;
  wire rx_full  = rx_cnt >= rx_cap;
  wire rx_acc   = rx_done_r && (!rx_full || rx_pop);
  wire rx_ovr   = rx_done_r && rx_full && !rx_pop;
  wire rx_ovwr  = rx_ovr && !fen_r;                 // unread buffer overwritten
  wire word_err = |rx_word_r[10:8];
  wire head_err = |rxq[rx_rp][10:8];
  // a new character reaches the head of the queue
  wire head_new = (rx_acc && (rx_cnt == '0 || (rx_pop && rx_cnt == (RAW+1)'(1))))
                || (rx_pop && rx_cnt > (RAW+1)'(1)) || rx_ovwr;

  always_ff @(posedge clk) begin
    if (ce && rx_acc) rxq[rx_wp] <= rx_word_r;
    else if (ce && rx_ovwr) rxq[rx_rp] <= rx_word_r;
  end

  // the counts step up and down in one cycle when push and pop meet
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
      rx_errs <= '0;
      head_new_d_r <= 1'b0;
    end else if (ce) begin
      head_new_d_r <= head_new && !rx_clr;
      if (rx_clr) begin
        rx_wp <= '0;
        rx_rp <= '0;
        rx_cnt <= '0;
        rx_errs <= '0;
      end else begin
        if (rx_acc) rx_wp <= rx_wp + 1'b1;
        if (rx_pop) rx_rp <= rx_rp + 1'b1;
        rx_cnt <= rx_cnt + (RAW+1)'(rx_acc) - (RAW+1)'(rx_pop);
        rx_errs <= rx_errs + (RAW+1)'(rx_acc && word_err)
                 - (RAW+1)'(rx_pop && head_err);
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  rx_state_t  rx_st;
  logic [3:0] rx_sc;
  logic [2:0] rx_idx;
  logic [7:0] rx_sh;
  logic       rx_par_r, rx_zero_r;
  logic [1:0] rx_hi;

  wire rx_bit_end = rx_sc == BIT_LAST[3:0];
  wire rx_perr = lcr_r[LC_PEN] && (rx_par_r != par_bit(rx_sh, lcr_r));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_st <= RX_IDLE;
      rx_sc <= '0;
      rx_idx <= '0;
      rx_sh <= '0;
      rx_par_r <= 1'b0;
      rx_zero_r <= 1'b0;
      rx_hi <= '0;
      rx_done_r <= 1'b0;
      rx_word_r <= '0;
    end else if (ce) begin
      rx_done_r <= 1'b0;
      if (tick16) begin
        rx_sc <= rx_sc + 1'b1;
        unique case (rx_st)
          RX_IDLE: begin
            rx_sc <= '0;
            if (!rxd) rx_st <= RX_START;
          end
          RX_START: if (rx_sc == SMP_MID) begin
            rx_sc <= '0;
            rx_idx <= '0;
            rx_sh <= '0;
            rx_zero_r <= 1'b1;
            rx_st <= rxd ? RX_IDLE : RX_DATA;  // high at mid-bit is a false start
          end
          RX_DATA: if (rx_bit_end) begin
            rx_sh[rx_idx] <= rxd;
            rx_zero_r <= rx_zero_r && !rxd;
            rx_idx <= rx_idx + 1'b1;
            if (rx_idx == last_bit(lcr_r)) rx_st <= lcr_r[LC_PEN] ? RX_PAR : RX_STOP;
          end
          RX_PAR: if (rx_bit_end) begin
            rx_par_r <= rxd;
            rx_zero_r <= rx_zero_r && !rxd;
            rx_st <= RX_STOP;
          end
          RX_STOP: if (rx_bit_end) begin
            rx_done_r <= 1'b1;
            rx_sc <= '0;
            rx_hi <= '0;
            if (rxd) begin
              rx_word_r <= {2'b00, rx_perr, rx_sh};
              rx_st <= RX_IDLE;
            end else if (rx_zero_r) begin
              rx_word_r <= {3'b100, 8'h00};
              rx_st <= RX_BRK;
            end else begin
              rx_word_r <= {2'b01, rx_perr, rx_sh};
              rx_st <= RX_START;                     // low stop taken as next start
            end
          end
          RX_BRK: begin
            rx_hi <= rxd ? rx_hi + 1'b1 : 2'h0;
            if (rxd && rx_hi == BRK_HIGH - 2'h1) rx_st <= RX_IDLE;
          end
          default: rx_st <= RX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // line status flags; a set in the cycle of a status read wins
  // ----------------------------------------------------------------
  wire [2:0] head_flags = head_new_d_r ? rxq[rx_rp][10:8] : 3'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {oe_r, pe_r, fe_r, bi_r} <= 4'h0;
    end else if (ce) begin
      oe_r <= (oe_r && !rd_lsr) || rx_ovr;
      pe_r <= (pe_r && !rd_lsr) || head_flags[0];
      fe_r <= (fe_r && !rd_lsr) || head_flags[1];
      bi_r <= (bi_r && !rd_lsr) || head_flags[2];
    end
  end

  // ----------------------------------------------------------------
  // transmit queue and shift register
  // ----------------------------------------------------------------
  logic [7:0]   txq [TX_DEPTH];
  logic [TAW-1:0] tx_wp, tx_rp;
  logic [TAW:0] tx_cnt;
  tx_state_t    tx_st;
  logic [4:0]   tx_sc;
  logic [2:0]   tx_idx;
  logic [7:0]   tsr_r;
  logic         txd_r;

  wire [TAW:0] tx_cap = fen_r ? TX_FULL : (TAW+1)'(1);
  wire tx_push = wr_thr && tx_cnt < tx_cap;  // writes to a full holder are dropped
  wire tx_load = tx_st == TX_IDLE && tx_cnt != '0;
  wire holder_empty_flag    = tx_cnt == '0;
  wire transmitter_empty_flag    = holder_empty_flag && tx_st == TX_IDLE;
  wire [4:0] stop_last = !lcr_r[LC_STB] ? BIT_LAST :
                         (lcr_r[1:0] == 2'h0 ? STOP_15 : STOP_2);

  always_ff @(posedge clk) begin
    if (ce && tx_push) txq[tx_wp] <= wdata;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else if (ce) begin
      if (tx_clr) begin
        tx_wp <= '0;
        tx_rp <= '0;
        tx_cnt <= '0;
      end else begin
        if (tx_push) tx_wp <= tx_wp + 1'b1;
        if (tx_load) tx_rp <= tx_rp + 1'b1;
        tx_cnt <= tx_cnt + (TAW+1)'(tx_push) - (TAW+1)'(tx_load);
      end
    end
  end

  // start bit goes out at once; data and parity bits last sixteen ticks, the stop time sixteen, 24 or 32 ticks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_st <= TX_IDLE;
      tx_sc <= '0;
      tx_idx <= '0;
      tsr_r <= '0;
      txd_r <= 1'b1;
    end else if (ce) begin
      if (tx_load) begin
        tsr_r <= txq[tx_rp];
        tx_sc <= '0;
        txd_r <= 1'b0;
        tx_st <= TX_START;
      end else if (tick16 && tx_st != TX_IDLE) begin
        tx_sc <= tx_sc + 1'b1;
        if (tx_sc == (tx_st == TX_STOP ? stop_last : BIT_LAST)) begin
          tx_sc <= '0;
          unique case (tx_st)
            TX_START: begin
              tx_idx <= '0;
              txd_r <= tsr_r[0];
              tx_st <= TX_DATA;
            end
            TX_DATA: if (tx_idx == last_bit(lcr_r)) begin
              txd_r <= lcr_r[LC_PEN] ? par_bit(tsr_r, lcr_r) : 1'b1;
              tx_st <= lcr_r[LC_PEN] ? TX_PAR : TX_STOP;
            end else begin
              tx_idx <= tx_idx + 1'b1;
              txd_r <= tsr_r[tx_idx + 3'h1];
            end
            TX_PAR: begin
              txd_r <= 1'b1;
              tx_st <= TX_STOP;
            end
            TX_STOP: tx_st <= TX_IDLE;
            default: tx_st <= TX_IDLE;
          endcase
        end
      end
    end
  end

  // break only gates the line, the shift register keeps running
  assign tx_pin = txd_r && !lcr_r[LC_BRK];

  // ----------------------------------------------------------------
  // modem deltas and interrupt identification
  // ----------------------------------------------------------------
  wire [3:0] mchg = m2_r ^ mprev_r;
  wire [3:0] mset = {mchg[3], m2_r[2] && !mprev_r[2], mchg[1:0]};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dlt_r <= 4'h0;
    end else if (ce) begin
      dlt_r <= (dlt_r & {4{!rd_msr}}) | mset;
    end
  end

  wire rls_act  = ier_r[2] && (oe_r || pe_r || fe_r || bi_r);
  wire rda_act  = ier_r[0] && rx_cnt != '0;
  wire holder_empty_flag_act = ier_r[1] && holder_empty_flag_int_r;
  wire ms_act   = ier_r[3] && dlt_r != 4'h0;
  wire [3:0] iid = rls_act ? IID_RLS :
                   rda_act ? IID_RDA :
                   holder_empty_flag_act ? IID_HOLDER_EMPTY_FLAG :
                   ms_act ? IID_MS : IID_NONE;

  // holder-empty event: emptied, or enabled while already empty
  wire holder_empty_flag_set = (holder_empty_flag && !holder_empty_flag_d_r) || (wr_ier && wdata[1] && !ier_r[1] && holder_empty_flag);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      holder_empty_flag_d_r <= 1'b1;
      holder_empty_flag_int_r <= 1'b0;
    end else if (ce) begin
      holder_empty_flag_d_r <= holder_empty_flag;
      holder_empty_flag_int_r <= (holder_empty_flag_int_r && !wr_thr && !(rd_iir && iid == IID_HOLDER_EMPTY_FLAG))
                  || holder_empty_flag_set;
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  wire fifo_error_summary = fen_r && rx_errs != '0;
  wire [7:0] line_status = {fifo_error_summary, transmitter_empty_flag, holder_empty_flag, bi_r, fe_r, pe_r, oe_r, rx_cnt != '0};
  wire [7:0] rd_mux =
    addr == ADDR_DATA ? (divisor_access_field ? dll_r : rxq[rx_rp][7:0]) :
    addr == ADDR_IER  ? (divisor_access_field ? dlm_r : {4'h0, ier_r}) :
    addr == ADDR_IIR  ? {fen_r ? IIR_FIFO : 2'h0, 2'h0, iid} :
    addr == ADDR_LCR  ? lcr_r :
    addr == ADDR_LSR  ? line_status :
    addr == ADDR_MSR  ? {~m2_r, dlt_r} : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata_r <= 8'h00;
    else if (ce && rd) rdata_r <= rd_mux;
  end

  assign rdata     = rdata_r;
  assign irq       = iid != IID_NONE;
  assign divisor   = {dlm_r, dll_r};
  assign fifo_mode = fen_r;

endmodule

// file: uart_lfs_checker_asserts.sv
`timescale 1ns/1ps
module uart_lfs_checker
  import uart_lfs_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        tick16,
  input wire logic [2:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        rx_pin,
  input wire logic        tx_pin,
  input wire logic [3:0]  modem_n,
  input wire logic        irq,
  input wire logic [15:0] divisor,
  input wire logic        fifo_mode
);
  // ----------------------------------------------------------------
  // line control shadow, kept from host writes only
  // ----------------------------------------------------------------
  logic [7:0] lcr_r;
  wire        take_wr = ce && wr;
  wire        take_rd = ce && rd;

  // same edge as the design, so break and access bits line up exactly
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      lcr_r <= 8'h00;
    else if (take_wr && addr == ADDR_LCR)
      lcr_r <= wdata;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_rd(logic [2:0] a);
    take_rd && addr == a;
  endsequence
  sequence s_wr(logic [2:0] a);
    take_wr && addr == a;
  endsequence

  // read data is registered, so every read check looks one cycle after the strobe
  a_break_forces_low: assert property (lcr_r[LC_BRK] |-> !tx_pin)
    else $error("serial output not held low during break");
  a_div_low_load: assert property (s_wr(ADDR_DATA) ##0 lcr_r[LC_DIVISOR_ACCESS_FIELD]
    |=> divisor[7:0] == $past(wdata)) else $error("divisor low not loaded");
  a_div_high_load: assert property (s_wr(ADDR_IER) ##0 lcr_r[LC_DIVISOR_ACCESS_FIELD]
    |=> divisor[15:8] == $past(wdata)) else $error("divisor high not loaded");
  a_div_guarded: assert property (take_wr && !lcr_r[LC_DIVISOR_ACCESS_FIELD] |=> $stable(divisor))
    else $error("divisor changed with access bit clear");
  a_top_bit_zero: assert property (s_rd(ADDR_LSR) ##0 !fifo_mode |=> !rdata[7])
    else $error("status top bit set outside fifo mode");
  a_transmitter_empty_flag_needs_holder_empty_flag: assert property (s_rd(ADDR_LSR) |=> !rdata[6] || rdata[5])
    else $error("transmitter empty while holder full");
  a_iid_vs_irq: assert property (s_rd(ADDR_IIR) |=> rdata[0] == !$past(irq))
    else $error("pending bit disagrees with irq");
  a_iid_fifo_bits: assert property (s_rd(ADDR_IIR)
    |=> rdata[7:6] == {2{$past(fifo_mode)}}) else $error("fifo bits wrong in id");
  a_fifo_enable: assert property (s_wr(ADDR_IIR) |=> fifo_mode == $past(wdata[FC_EN]))
    else $error("fifo mode does not follow enable");
  a_lcr_readback: assert property (s_rd(ADDR_LCR) |=> rdata == $past(lcr_r))
    else $error("line control reads back wrong");
endmodule

bind uart_line_format_status uart_lfs_checker checker_i (
  .clk(clk), .nrst(nrst), .ce(ce), .tick16(tick16), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .modem_n(modem_n), .irq(irq), .divisor(divisor), .fifo_mode(fifo_mode));

// file: uart_serial_peer.sv
`timescale 1ns/1ps
module uart_serial_peer (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        tick16,
  input  wire logic        go,
  input  wire logic [15:0] frame,
  input  wire logic [4:0]  nbits,
  output logic             line,
  output logic             busy
);
  logic [15:0] sh_r;
  logic [4:0]  left_r;
  logic [3:0]  tc_r;

  // bits change just after a tick and last sixteen ticks; outside a frame the
  // line rests at mark, as the line's pull-up would hold it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line <= 1'b1;
      busy <= 1'b0;
      sh_r <= 16'h0000;
      left_r <= 5'h00;
      tc_r <= 4'h0;
    end else if (go) begin
      sh_r <= frame;
      left_r <= nbits;
      tc_r <= 4'hF;
      busy <= 1'b1;
    end else if (busy && tick16) begin
      tc_r <= tc_r + 4'h1;
      if (tc_r == 4'hF) begin
        line <= (left_r == 5'h00) ? 1'b1 : sh_r[0];
        busy <= (left_r != 5'h00);
        sh_r <= sh_r >> 1;
        left_r <= left_r - 5'h01;  // wrap is harmless, busy drops in the same cycle
      end
    end
  end
endmodule

// file: uart_line_format_status_tb_top.sv
`timescale 1ns/1ps
module uart_line_format_status_tb_top
  import uart_lfs_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus, serial peer and checks
  // ----------------------------------------------------------------
  logic        clk, nrst, ce, tick16, wr, rd, go, busy, rx_pin, tx_pin, irq, fifo_mode;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, got;
  logic [3:0]  modem_n;
  logic [15:0] divisor, fr;
  logic [4:0]  nb;
  logic [1:0]  tdiv = 2'h0;
  int          n_mismatch, num_checks, t;
  int          cyc = 0;
  logic [7:0]  tab [5] = '{8'h03, 8'h1A, 8'h09, 8'h28, 8'h3F};

  uart_line_format_status uart_line_format_status_i (.clk(clk), .nrst(nrst), .ce(ce),
    .tick16(tick16), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .modem_n(modem_n), .irq(irq), .divisor(divisor),
    .fifo_mode(fifo_mode));
  uart_serial_peer uart_serial_peer_i (.clk(clk), .nrst(nrst), .tick16(tick16), .go(go),
    .frame(fr), .nbits(nb), .line(rx_pin), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // tick every fourth clock keeps a bit at 64 clocks and the run short
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    tick16 <= (tdiv == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      summarize();
    end
  end

  task summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      n_mismatch++;
    end
  endtask
  task wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // let the write settle so a caller may look at outputs at once
    #1;
  endtask
  // plain read, the value lands in got
  task rreg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task rchk(input logic [2:0] a, input logic [7:0] e);
    rreg(a);
    chk(got, e);
  endtask
  // expected frame, start bit in bit 0, worked out from the format fields
  task mkf(input logic [7:0] d, input logic [7:0] v, input logic badp, input logic bads);
    int n;
    logic p;
    n = 5 + v[1:0];
    p = !v[LC_EPS];
    fr = 16'hFFFF;
    fr[0] = 1'b0;
    for (int i = 0; i < n; i++) begin
      fr[1 + i] = d[i];
      p = p ^ d[i];
    end
    if (v[LC_STICK]) p = !v[LC_EPS];
    nb = 5'(n + 1);
    if (v[LC_PEN]) begin
      fr[nb] = p ^ badp;
      nb++;
    end
    fr[nb] = !bads;
    nb++;
  endtask
  task shoot;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task send(input logic [7:0] d, input logic [7:0] v, input logic badp, input logic bads);
    mkf(d, v, badp, bads);
    shoot();
  endtask
  // sample the output line at mid-bit of every expected bit
  task txchk(input logic [7:0] d, input logic [7:0] v);
    mkf(d, v, 1'b0, 1'b0);
    wreg(ADDR_DATA, d);
    while (tx_pin !== 1'b0) @(posedge clk);
    repeat (32) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      chk({7'h00, tx_pin}, {7'h00, fr[i]});
      repeat (64) @(posedge clk);
    end
  endtask
  // two all-ones characters: high time from first data bit to next start, in half bits
  task gap(input logic [7:0] v, input logic [7:0] half);
    wreg(ADDR_LCR, v);
    wreg(ADDR_DATA, 8'hFF);
    repeat (4) @(posedge clk);
    wreg(ADDR_DATA, 8'hFF);
    rchk(ADDR_IIR, 8'h01);
    rchk(ADDR_LSR, 8'h00);
    while (tx_pin !== 1'b1) @(posedge clk);
    t = 0;
    while (tx_pin !== 1'b0 && t < 2000) begin
      @(posedge clk);
      t++;
    end
    chk(8'((t + 16) / 32), half);
    // poll without counting; the second character must drain within the bound
    t = 0;
    do begin
      rreg(ADDR_LSR);
      t++;
    end while (got !== 8'h60 && t < 400);
    chk(got, 8'h60);
  endtask

  initial begin
    {nrst, wr, rd, go, addr, wdata, fr, nb} = '0;
    ce = 1'b1;
    modem_n = 4'hF;
    {n_mismatch, num_checks} = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rchk(ADDR_LCR, 8'h00);
    // a write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wreg(ADDR_LCR, 8'h55);
    ce <= 1'b1;
    rchk(ADDR_LCR, 8'h00);
    rchk(ADDR_LSR, 8'h60);
    chk(divisor[7:0] | divisor[15:8], 8'h00);
    chk({5'h00, fifo_mode, tx_pin, irq}, 8'h02);
    rchk(3'h4, 8'h00);
    wreg(ADDR_LCR, 8'h80);
    wreg(ADDR_DATA, 8'h34);
    wreg(ADDR_IER, 8'h12);
    chk(divisor[15:8], 8'h12);
    rchk(ADDR_DATA, 8'h34);
    wreg(ADDR_LCR, 8'h43);
    @(posedge clk);
    chk({7'h00, tx_pin}, 8'h00);
    wreg(ADDR_LCR, 8'h03);
    @(posedge clk);
    chk({7'h00, tx_pin}, 8'h01);
    rchk(ADDR_IER, 8'h00);
    wreg(ADDR_IER, 8'h02);
    chk({7'h00, irq}, 8'h01);
    rchk(ADDR_IIR, 8'h02);
    rchk(ADDR_IIR, 8'h01);
    gap(8'h04, 8'd13);
    gap(8'h07, 8'd20);
    gap(8'h00, 8'd12);
    wreg(ADDR_IER, 8'h08);
    @(posedge clk);
    modem_n <= 4'hE;
    repeat (6) @(posedge clk);
    rchk(ADDR_IIR, 8'h00);
    rchk(ADDR_MSR, 8'h11);
    rchk(ADDR_IIR, 8'h01);
    wreg(ADDR_IER, 8'h00);
    foreach (tab[k]) begin
      wreg(ADDR_LCR, tab[k]);
      send(8'hA5, tab[k], 1'b0, 1'b0);
      rchk(ADDR_LSR, 8'h61);
      rchk(ADDR_DATA, 8'hA5 & (8'hFF >> (2'h3 - tab[k][1:0])));
      rchk(ADDR_LSR, 8'h60);
      txchk(8'hA5, tab[k]);
    end
    wreg(ADDR_LCR, 8'h1B);
    send(8'h5A, 8'h1B, 1'b1, 1'b0);
    rchk(ADDR_LSR, 8'h65);
    rchk(ADDR_LSR, 8'h61);
    rchk(ADDR_DATA, 8'h5A);
    wreg(ADDR_IER, 8'h05);
    send(8'h5A, 8'h1B, 1'b1, 1'b0);
    rchk(ADDR_IIR, 8'h06);
    rchk(ADDR_LSR, 8'h65);
    rchk(ADDR_IIR, 8'h04);
    rchk(ADDR_DATA, 8'h5A);
    wreg(ADDR_IER, 8'h00);
    wreg(ADDR_LCR, 8'h03);
    send(8'h11, 8'h03, 1'b0, 1'b0);
    send(8'h22, 8'h03, 1'b0, 1'b0);
    rchk(ADDR_LSR, 8'h63);
    rchk(ADDR_DATA, 8'h22);
    fr = 16'h0000;
    nb = 5'd14;
    shoot();
    rchk(ADDR_LSR, 8'h71);
    rchk(ADDR_DATA, 8'h00);
    send(8'h3C, 8'h03, 1'b0, 1'b0);
    rchk(ADDR_LSR, 8'h61);
    rchk(ADDR_DATA, 8'h3C);
    wreg(ADDR_IIR, 8'h01);
    rchk(ADDR_IIR, 8'hC1);
    wreg(ADDR_LCR, 8'h1B);
    send(8'h5A, 8'h1B, 1'b1, 1'b0);
    send(8'h3C, 8'h1B, 1'b0, 1'b0);
    rchk(ADDR_LSR, 8'hE5);
    rchk(ADDR_DATA, 8'h5A);
    rchk(ADDR_LSR, 8'h61);
    rchk(ADDR_DATA, 8'h3C);
    send(8'h55, 8'h1B, 1'b0, 1'b1);
    rchk(ADDR_LSR, 8'hE9);
    summarize();
  end
endmodule
